// >>> rtl/flash_host_ctrl.sv
// host-side controller issuing command sequences to a parallel nor flash
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// - word mode uses sixteen data lines, byte mode only the low eight
// - program takes four writes, or two while bypass is active
// - completion of program and erase is read from ready/busy pin and toggle bit
// - suspend is sent only while erasing_r is set, which the erase poll clears no later than the op ends; resume only while suspended
// - host drives separate chip select, write and output strobes
module flash_host_ctrl #(
  parameter int ADDR_W = flash_host_pkg::ADDR_W,
  parameter int DATA_W = flash_host_pkg::DATA_W,
  parameter int RESET_CYC = flash_host_pkg::RESET_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash pins
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  output logic flash_word_n_byte,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic ready_busy_n
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ISSUE = 4'b0001,
    ST_WAIT = 4'b0011,
    ST_POLL = 4'b0010,
    ST_POLL_WAIT = 4'b0110,
    ST_HWRESET = 4'b0111
  } state_e;

  // -----------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------
  logic [DATA_W-1:0] din_s1_r, din_s2_r;
  logic rb_s1_r, rb_s2_r;

  // pins from the flash pass two flops first
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_s1_r <= '0;
      din_s2_r <= '0;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end
    else if (clk_en)
    begin
      din_s1_r <= data_lines_in;
      din_s2_r <= din_s1_r;
      rb_s1_r <= ready_busy_n;
      rb_s2_r <= rb_s1_r;
    end
  end

  // -----------------------------------------------------------
  // software registers
  // -----------------------------------------------------------
  logic [3:0] op_r;
  logic word_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] rd_r;
  logic go;
  logic busy_r, done_r, bypass_r, susp_r, secure_r, erasing_r;
  logic hw_reset_req;

  assign go = reg_wr && reg_addr == flash_host_pkg::REG_CTRL;
  assign hw_reset_req = go && reg_wdata[flash_host_pkg::CTRL_RESET_BIT];

  // command latches, only accepted while idle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_r <= 4'h0;
      word_r <= flash_host_pkg::CTRL_WORD_RST;
      addr_r <= '0;
      data_r <= '0;
    end
    else if (clk_en && !busy_r)
    begin
      if (go)
      begin
        op_r <= reg_wdata[flash_host_pkg::CTRL_OP_LSB +: 4];
        word_r <= reg_wdata[flash_host_pkg::CTRL_WORD_BIT];
      end
      if (reg_wr && reg_addr == flash_host_pkg::REG_ADDR)
        addr_r <= reg_wdata[ADDR_W-1:0];
      if (reg_wr && reg_addr == flash_host_pkg::REG_DATA)
        data_r <= reg_wdata[DATA_W-1:0];
    end
  end

  // read data answer one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
        case (reg_addr)
          flash_host_pkg::REG_CTRL:
            reg_rdata <= 32'({word_r, op_r});
          flash_host_pkg::REG_ADDR: reg_rdata <= 32'(addr_r);
          flash_host_pkg::REG_DATA: reg_rdata <= 32'(data_r);
          flash_host_pkg::REG_STATUS:
            reg_rdata <= 32'({secure_r, rb_s2_r, susp_r, bypass_r,
                              done_r, busy_r});
          flash_host_pkg::REG_RDATA: reg_rdata <= 32'(rd_r);
          default: reg_rdata <= 32'h0000_0000;
        endcase
    end
  end

  // -----------------------------------------------------------
  // command sequencer
  // -----------------------------------------------------------
  state_e state_r;
  logic [2:0] step_r, nsteps_r;
  logic [7:0] rst_cnt_r;
  logic poll_r;
  logic [7:0] last_r;
  logic cyc_start, cyc_write, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_data, cyc_rdata;
  logic [2:0] seq_len;
  logic bad_op;

  // number of writes per operation
  always_comb
  begin
    bad_op = 1'b0;
    case (op_r)
      flash_host_pkg::OP_READ: seq_len = 3'd0;
      flash_host_pkg::OP_PROGRAM: seq_len = bypass_r ? 3'd2 : 3'd4;
      flash_host_pkg::OP_SECTOR_ERASE,
      flash_host_pkg::OP_CHIP_ERASE: seq_len = 3'd6;
      flash_host_pkg::OP_BYPASS_ENTER,
      flash_host_pkg::OP_SECURE_ENTER,
      flash_host_pkg::OP_SECURE_EXIT: seq_len = 3'd3;
      flash_host_pkg::OP_BYPASS_EXIT: seq_len = 3'd2;
      // suspend only while erasing and not yet suspended, resume only while suspended
      flash_host_pkg::OP_SUSPEND: seq_len = erasing_r && !susp_r ? 3'd1 : 3'd0;
      flash_host_pkg::OP_RESUME: seq_len = susp_r ? 3'd1 : 3'd0;
      flash_host_pkg::OP_CFI_QUERY,
      flash_host_pkg::OP_RESET_CMD: seq_len = 3'd1;
      default:
      begin
        seq_len = 3'd0;
        bad_op = 1'b1;
      end
    endcase
  end

  // address and data of each write of the sequence
  always_comb
  begin
    logic [2:0] s;
    s = step_r;
    if (op_r == flash_host_pkg::OP_PROGRAM && bypass_r)
      s = step_r + 3'd2;
    cyc_addr = ADDR_W'(flash_host_pkg::UNLOCK1_ADDR);
    cyc_data = DATA_W'(flash_host_pkg::UNLOCK1_DATA);
    if (s == 3'd1 || s == 3'd4)
    begin
      cyc_addr = ADDR_W'(flash_host_pkg::UNLOCK2_ADDR);
      cyc_data = DATA_W'(flash_host_pkg::UNLOCK2_DATA);
    end
    case (op_r)
      flash_host_pkg::OP_PROGRAM:
        if (s == 3'd2) cyc_data = DATA_W'(flash_host_pkg::CMD_PROGRAM);
        else if (s == 3'd3)
        begin
          cyc_addr = addr_r;
          cyc_data = data_r;
        end
      flash_host_pkg::OP_SECTOR_ERASE,
      flash_host_pkg::OP_CHIP_ERASE:
        if (s == 3'd2) cyc_data = DATA_W'(flash_host_pkg::CMD_ERASE_SETUP);
        else if (s == 3'd5 && op_r == flash_host_pkg::OP_SECTOR_ERASE)
        begin
          cyc_addr = addr_r;
          cyc_data = DATA_W'(flash_host_pkg::CMD_SECTOR_ERASE);
        end
        else if (s == 3'd5)
          cyc_data = DATA_W'(flash_host_pkg::CMD_CHIP_ERASE);
      flash_host_pkg::OP_BYPASS_ENTER:
        if (s == 3'd2) cyc_data = DATA_W'(flash_host_pkg::CMD_BYPASS_ENTER);
      flash_host_pkg::OP_SECURE_ENTER:
        if (s == 3'd2) cyc_data = DATA_W'(flash_host_pkg::CMD_SECURE_ENTER);
      flash_host_pkg::OP_SECURE_EXIT:
        if (s == 3'd2) cyc_data = DATA_W'(flash_host_pkg::CMD_SECURE_EXIT);
      flash_host_pkg::OP_BYPASS_EXIT:
        cyc_data = DATA_W'(s == 3'd0 ? flash_host_pkg::CMD_BYPASS_EXIT1
                                     : flash_host_pkg::CMD_BYPASS_EXIT2);
      flash_host_pkg::OP_SUSPEND:
        cyc_data = DATA_W'(flash_host_pkg::CMD_SUSPEND);
      flash_host_pkg::OP_RESUME:
        cyc_data = DATA_W'(flash_host_pkg::CMD_RESUME);
      flash_host_pkg::OP_CFI_QUERY:
      begin
        cyc_addr = ADDR_W'(flash_host_pkg::CFI_ADDR);
        cyc_data = DATA_W'(flash_host_pkg::CMD_CFI);
      end
      flash_host_pkg::OP_RESET_CMD:
        cyc_data = DATA_W'(flash_host_pkg::CMD_RESET);
      default:
        cyc_addr = addr_r;
    endcase
  end

  // compare with this op's length, nsteps_r still holds the last op's
  assign cyc_write = state_r == ST_ISSUE && step_r != seq_len;
  assign cyc_start = state_r == ST_ISSUE || state_r == ST_POLL;

  // main sequencer; the device runs its own algorithms
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      step_r <= 3'd0;
      nsteps_r <= 3'd0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      poll_r <= 1'b0;
      last_r <= 8'h00;
      rd_r <= '0;
      rst_cnt_r <= 8'h00;
      flash_reset_n <= 1'b0;
    end
    else if (clk_en)
    begin
      flash_reset_n <= state_r != ST_HWRESET;
      if (go && !busy_r)
        done_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (hw_reset_req && !busy_r)
          begin
            state_r <= ST_HWRESET;
            busy_r <= 1'b1;
            rst_cnt_r <= 8'(RESET_CYC);
          end
          else if (go && !busy_r)
          begin
            busy_r <= 1'b1;
            step_r <= 3'd0;
            state_r <= ST_ISSUE;
          end
        ST_ISSUE:
        begin
          nsteps_r <= seq_len;
          // an op with no writes is a plain array read
          poll_r <= op_r == flash_host_pkg::OP_PROGRAM
                    || op_r == flash_host_pkg::OP_SECTOR_ERASE
                    || op_r == flash_host_pkg::OP_CHIP_ERASE;
          state_r <= ST_WAIT;
        end
        ST_WAIT:
          if (cyc_done)
          begin
            if (step_r + 3'd1 < nsteps_r)
            begin
              step_r <= step_r + 3'd1;
              state_r <= ST_ISSUE;
            end
            else if (poll_r)
              state_r <= ST_POLL;
            else
            begin
              rd_r <= cyc_rdata;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        ST_POLL:
          state_r <= ST_POLL_WAIT;
        ST_POLL_WAIT:
          if (cyc_done)
          begin
            last_r <= cyc_rdata[7:0];
            // stop when toggle bit is steady and ready/busy high
            if (rb_s2_r && cyc_rdata[6] == last_r[6])
            begin
              rd_r <= cyc_rdata;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= ST_IDLE; // device back in array read
            end
            else
              state_r <= ST_POLL;
          end
        ST_HWRESET:
          if (rst_cnt_r != 8'h00)
            rst_cnt_r <= rst_cnt_r - 8'h01;
          else
          begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // mode flags tracked from issued commands
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bypass_r <= 1'b0;
      susp_r <= 1'b0;
      secure_r <= 1'b0;
      erasing_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_r == ST_HWRESET)
      begin
        bypass_r <= 1'b0;
        susp_r <= 1'b0;
        secure_r <= 1'b0;
        erasing_r <= 1'b0;
      end
      else if (state_r == ST_WAIT && cyc_done && step_r + 3'd1 >= nsteps_r
               && nsteps_r != 3'd0)
        case (op_r)
          flash_host_pkg::OP_BYPASS_ENTER: bypass_r <= 1'b1;
          flash_host_pkg::OP_BYPASS_EXIT: bypass_r <= 1'b0;
          flash_host_pkg::OP_SECURE_ENTER: secure_r <= 1'b1;
          flash_host_pkg::OP_SECURE_EXIT: secure_r <= 1'b0;
          flash_host_pkg::OP_SUSPEND: susp_r <= 1'b1;
          flash_host_pkg::OP_RESUME: susp_r <= 1'b0;
          flash_host_pkg::OP_SECTOR_ERASE,
          flash_host_pkg::OP_CHIP_ERASE: erasing_r <= 1'b1;
          default: erasing_r <= erasing_r;
        endcase
      else if (state_r == ST_POLL_WAIT && cyc_done && rb_s2_r
               && !susp_r)
        erasing_r <= 1'b0;
    end
  end

  // byte or word pin, registered
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flash_word_n_byte <= flash_host_pkg::CTRL_WORD_RST;
    else if (clk_en)
      flash_word_n_byte <= word_r;
  end

  // -----------------------------------------------------------
  // pin cycle engine
  // -----------------------------------------------------------
  flash_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_cycle (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(cyc_start),
    .is_write(cyc_write && !bad_op),
    .word_mode(word_r),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .ce_n(flash_ce_n),
    .we_n(flash_we_n),
    .oe_n(flash_oe_n),
    .addr_pins(flash_addr),
    .data_out(data_lines_out),
    .data_oe(data_lines_oe),
    .data_in(din_s2_r)
  );
endmodule

// >>> rtl/flash_host_pkg.sv
// constants shared by the flash host controller and its bus cycle engine
package flash_host_pkg;
  // device geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_COUNT = 1048576;
  localparam int WORD_COUNT = 524288;
  localparam int BOOT_SECTORS = 8;
  localparam int MAIN_SECTORS = 15;
  localparam int BOOT_SECTOR_BYTES = 8192;
  localparam int MAIN_SECTOR_BYTES = 65536;
  localparam int SECURE_WORDS = 128;
  localparam int SERIAL_WORDS = 8;
  // command interface register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 4;
  localparam int CTRL_WORD_BIT = 4;
  localparam int CTRL_RESET_BIT = 5;
  localparam logic CTRL_WORD_RST = 1'b1;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_BYPASS_BIT = 2;
  localparam int ST_SUSP_BIT = 3;
  localparam int ST_RB_BIT = 4;
  localparam int ST_SECURE_BIT = 5;
  // operations requested by software
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_PROGRAM = 4'h2;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h3;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
  localparam logic [3:0] OP_BYPASS_ENTER = 4'h5;
  localparam logic [3:0] OP_BYPASS_EXIT = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;
  localparam logic [3:0] OP_SECURE_ENTER = 4'h9;
  localparam logic [3:0] OP_SECURE_EXIT = 4'hA;
  localparam logic [3:0] OP_CFI_QUERY = 4'hB;
  localparam logic [3:0] OP_RESET_CMD = 4'hC;
  // command codes and unlock addresses (device variant specific)
  localparam logic [15:0] UNLOCK1_ADDR = 16'h0555;
  localparam logic [15:0] UNLOCK2_ADDR = 16'h02AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BYPASS_ENTER = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SECURE_ENTER = 8'h88;
  localparam logic [7:0] CMD_SECURE_EXIT = 8'h90;
  localparam logic [7:0] CMD_CFI = 8'h98;
  localparam logic [15:0] CFI_ADDR = 16'h0055;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // bus timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACCESS_NS = 70;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_NS = 40;
  localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
endpackage

// >>> rtl/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/10ps
module flash_bus_cycle #(
  parameter int ADDR_W = flash_host_pkg::ADDR_W,
  parameter int DATA_W = flash_host_pkg::DATA_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // request from the sequencer
  input wire logic start,
  input wire logic is_write,
  input wire logic word_mode,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // flash pins
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [ADDR_W-1:0] addr_pins,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in
);
  localparam logic [7:0] RD_CYC = 8'(flash_host_pkg::ACCESS_CYC + 2);
  localparam logic [7:0] WR_CYC = 8'(flash_host_pkg::WE_CYC);

  // -----------------------------------------------------------
  // cycle engine
  // -----------------------------------------------------------
  logic [7:0] cnt_r;
  logic busy_r;
  logic wr_r;

  // strobes are separate so read and write never share the bus
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      wr_r <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      addr_pins <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (!busy_r && start)
      begin
        busy_r <= 1'b1;
        wr_r <= is_write;
        addr_pins <= addr;
        // byte mode zeroes the high lane
        data_out <= word_mode ? wdata : {8'h00, wdata[7:0]};
        data_oe <= is_write;
        ce_n <= 1'b0;
        we_n <= !is_write;
        oe_n <= is_write;
        cnt_r <= is_write ? WR_CYC : RD_CYC;
      end
      else if (busy_r)
      begin
        if (cnt_r != 8'h00)
          cnt_r <= cnt_r - 8'h01;
        else
        begin
          // data_in was synchronised two stages, sampled late in cycle
          if (!wr_r)
            rdata <= word_mode ? data_in : {8'h00, data_in[7:0]};
          busy_r <= 1'b0;
          done <= 1'b1;
          ce_n <= 1'b1;
          we_n <= 1'b1;
          oe_n <= 1'b1;
          data_oe <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> testbench/flash_host_props.sv
// pin protocol checker for the flash host controller
`timescale 1ns/10ps
module flash_host_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // watched ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [flash_host_pkg::DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // a write pulse starts selected and must stay low long enough to latch
  sequence s_we_start;
    $fell(flash_we_n) && !flash_ce_n;
  endsequence
  sequence s_we_hold;
    (!flash_we_n)[*4];
  endsequence
  a_we_width: assert property (s_we_start |-> s_we_hold)
    else $error("write strobe pulse too short");
  a_no_contend: assert property (flash_we_n || flash_oe_n)
    else $error("write and output strobes low together");
  a_oe_released: assert property (!flash_oe_n |-> !data_lines_oe)
    else $error("host drives data during a read");
  a_we_selects: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe without chip select");
  a_write_drives: assert property (!flash_we_n |-> data_lines_oe)
    else $error("write cycle without data driven");
  a_write_steady: assert property (!flash_we_n && !$past(flash_we_n) |->
    $stable(flash_addr) && $stable(data_lines_out))
    else $error("address or data moved inside a write");
  a_read_steady: assert property (!flash_oe_n && !$past(flash_oe_n) |->
    $stable(flash_addr))
    else $error("address moved inside a read");
  a_reset_quiet: assert property (!flash_reset_n |->
    flash_we_n && flash_oe_n)
    else $error("strobes active while device held in reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

bind flash_host_ctrl flash_host_props chk (
  .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
  .flash_reset_n(flash_reset_n), .flash_addr(flash_addr),
  .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe)
);

// >>> testbench/flash_device_model.sv
// behavioural model of the parallel nor flash behind the controller
`timescale 1ns/10ps
module flash_device_model #(
  parameter int PROG_NS = 600,
  parameter int ERASE_NS = 3000
) (
  // strobes
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic reset_n,
  input wire logic word_mode,
  // address and data
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic rb_n,
  // hardware resets seen
  output int resets
);
  // ----
  // state
  // ----
  logic [15:0] mem [256];
  logic [2:0] st = 3'h0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic pbit = 1'b1;
  logic [15:0] rv;
  logic [15:0] lastv = 16'h0000;
  logic u1, u2;
  // sparse array: sector number plus low address bits keeps it small
  function automatic logic [7:0] key(input logic [19:0] x);
    return {x[19:15], x[2:0]};
  endfunction
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    resets = 0;
  end
  assign u1 = dq_in[7:0] == flash_host_pkg::UNLOCK1_DATA &&
    addr[10:0] == flash_host_pkg::UNLOCK1_ADDR[10:0];
  assign u2 = dq_in[7:0] == flash_host_pkg::UNLOCK2_DATA &&
    addr[10:0] == flash_host_pkg::UNLOCK2_ADDR[10:0];
  // busy ends on its own after the self-timed interval
  task automatic run(input int t);
    busy <= 1'b1;
    busy <= #(t) 1'b0;
    st = 3'h0;
  endtask
  // abort everything on the reset pin
  always @(negedge reset_n)
  begin
    st = 3'h0;
    busy <= 1'b0;
    resets++;
  end
  // sample a moment after the fall, strobes may move together
  always @(negedge we_n)
  begin
    #1;
    if (!ce_n && reset_n && !busy)
    begin
      case (st)
        3'h0, 3'h4: st = u1 ? st + 3'h1 : 3'h0;
        3'h1, 3'h5: st = u2 ? st + 3'h1 : 3'h0;
        3'h2: st = dq_in[7:0] == flash_host_pkg::CMD_PROGRAM ? 3'h3 :
          dq_in[7:0] == flash_host_pkg::CMD_ERASE_SETUP ? 3'h4 : 3'h0;
        3'h3:
        begin
          mem[key(addr)] = mem[key(addr)] & dq_in;
          pbit = dq_in[7];
          run(PROG_NS);
        end
        3'h6:
        begin
          if (dq_in[7:0] == flash_host_pkg::CMD_SECTOR_ERASE)
          begin
            foreach (mem[i]) if (i[7:3] == addr[19:15]) mem[i] = 16'hFFFF;
            pbit = 1'b1;
            run(ERASE_NS);
          end
          st = 3'h0;
        end
        default: st = 3'h0;
      endcase
    end
  end
  // status while busy, array data otherwise; byte mode garbles the top
  assign rv = busy ? {8'h00, ~pbit, tog, 6'h00} :
    word_mode ? mem[key(addr)] : {8'hA5, mem[key(addr)][7:0]};
  assign dq_out = (!ce_n && !oe_n) ? rv : ~lastv;
  assign rb_n = ~busy;
  always @(posedge oe_n) lastv = rv;
  always @(negedge oe_n)
  begin
    #1;
    if (!ce_n && busy) tog = ~tog;
  end
endmodule

// >>> testbench/flash_host_ctrl_test.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_test;
  // ----
  // bench signals
  // ----
  localparam logic [19:0] A1 = 20'h00010;
  localparam logic [19:0] A2 = 20'h10011;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, st;
  logic ce_n, we_n, oe_n, frst_n, word, doe, rb_n;
  logic [19:0] faddr;
  logic [15:0] dout, din, mdq;
  int err_total = 0;
  int checks = 0;
  int wcnt = 0;
  int resets;
  always #5 clock = ~clock;
  always @(negedge we_n) wcnt++;
  // the wire level: host when it drives, otherwise the device
  assign din = doe ? dout : mdq;
  flash_host_ctrl #(.RESET_CYC(2)) dut (
    .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_reset_n(frst_n), .flash_word_n_byte(word),
    .flash_addr(faddr), .data_lines_out(dout), .data_lines_oe(doe),
    .data_lines_in(din), .ready_busy_n(rb_n)
  );
  flash_device_model dev (
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(frst_n),
    .word_mode(word), .addr(faddr), .dq_in(din), .dq_out(mdq),
    .rb_n(rb_n), .resets(resets)
  );
  task automatic final_report;
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // start one operation and poll status, bounded
  task automatic op(input logic [5:0] c, input logic [19:0] a,
    input logic [15:0] d);
    int n;
    wr(flash_host_pkg::REG_ADDR, {12'h000, a});
    wr(flash_host_pkg::REG_DATA, {16'h0000, d});
    wr(flash_host_pkg::REG_CTRL, {26'h0, c});
    n = 0;
    do
    begin
      rd(flash_host_pkg::REG_STATUS, st);
      n++;
    end
    while (st[0] !== 1'b0 && n < 2000);
    if (n >= 2000)
    begin
      cmp("poll", 32'h0, 32'h1);
      final_report();
    end
  endtask
  task automatic chk_read(input logic w, input logic [19:0] a,
    input logic [31:0] e, input string n);
    logic [31:0] v;
    op({1'b0, w, flash_host_pkg::OP_READ}, a, 16'h0000);
    rd(flash_host_pkg::REG_RDATA, v);
    cmp(n, e, v);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_prog_erase;
    op({2'b01, flash_host_pkg::OP_PROGRAM}, A1, 16'h1234);
    cmp("done", 32'h1, {31'h0, st[flash_host_pkg::ST_DONE_BIT]});
    cmp("ready", 32'h1, {31'h0, rb_n});
    op({2'b01, flash_host_pkg::OP_PROGRAM}, A2, 16'hBEEF);
    chk_read(1'b1, A1, 32'h1234, "word1");
    op({2'b01, flash_host_pkg::OP_SECTOR_ERASE}, A1, 16'h0000);
    cmp("erase ready", 32'h1, {31'h0, rb_n});
    chk_read(1'b1, A1, 32'hFFFF, "erased");
    chk_read(1'b1, A2, 32'hBEEF, "kept");
  endtask
  // unknown op and stray suspend or resume issue no write cycles
  task automatic t_refuse;
    int w0;
    w0 = wcnt;
    op(6'h1F, A1, 16'h0000);
    op({2'b01, flash_host_pkg::OP_SUSPEND}, A1, 16'h0000);
    op({2'b01, flash_host_pkg::OP_RESUME}, A1, 16'h0000);
    cmp("writes", 32'(w0), 32'(wcnt));
    chk_read(1'b1, A2, 32'hBEEF, "array");
  endtask
  task automatic t_hwreset;
    int r0;
    r0 = resets;
    op(6'h30, A1, 16'h0000);
    cmp("resets", 32'(r0 + 1), 32'(resets));
    cmp("reset pin", 32'h1, {31'h0, frst_n});
    chk_read(1'b1, A2, 32'hBEEF, "after reset");
  endtask
  // bypass shortens program; secure mode is tracked and the query takes one write
  task automatic t_modes;
    int w0;
    op({2'b01, flash_host_pkg::OP_BYPASS_ENTER}, A1, 16'h0000);
    cmp("bypass", 32'h1, 32'(st[flash_host_pkg::ST_BYPASS_BIT]));
    w0 = wcnt;
    op({2'b01, flash_host_pkg::OP_PROGRAM}, A1, 16'h00FF);
    cmp("bypass writes", 32'(w0 + 2), 32'(wcnt));
    op({2'b01, flash_host_pkg::OP_BYPASS_EXIT}, A1, 16'h0000);
    op({2'b01, flash_host_pkg::OP_SECURE_ENTER}, A1, 16'h0000);
    cmp("secure", 32'h1, 32'(st[flash_host_pkg::ST_SECURE_BIT]));
    op({2'b01, flash_host_pkg::OP_SECURE_EXIT}, A1, 16'h0000);
    w0 = wcnt;
    op({2'b01, flash_host_pkg::OP_CFI_QUERY}, A1, 16'h0000);
    cmp("query writes", 32'(w0 + 1), 32'(wcnt));
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_prog_erase();
    t_refuse();
    chk_read(1'b0, A2, 32'h00EF, "byte");
    t_modes();
    t_hwreset();
    final_report();
  end
endmodule
